// ---- hdl/nand_host_pkg.sv ----
/*
 Package for the NAND flash host controller: command codes, address field layout,
 timing counts at a 250 MHz clock and the request and pin control carriers.
 Assumes a byte-wide multiplexed NAND part behind the pins.
*/
package nand_host_pkg;
   localparam int CLK_MHZ = 250;
   // Command codes
   localparam logic [7:0] CMD_READ_LO = 8'h00;
   localparam logic [7:0] CMD_READ_HI = 8'h01;
   localparam logic [7:0] CMD_READ_SPARE = 8'h50;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
   localparam logic [7:0] CMD_PROG_GO = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   // Address layout
   localparam int COL_LSB = 0;
   localparam int A8_BIT = 8;
   localparam int ROW_LO_LSB = 9;
   localparam int ROW_HI_LSB = 17;
   localparam int ROW_HI_W = 6;
   localparam int PAGE_BYTES = 528;
   // Timing
   localparam int POWERUP_NS = 1000;
   localparam int POWERUP_CYC = (POWERUP_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_BUSY_NS = 5000;
   localparam int RESET_BUSY_CYC = (RESET_BUSY_NS * CLK_MHZ) / 1000;
   localparam int STROBE_NS = 28;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int BUSY_SETTLE_CYC = 25;

   typedef enum logic [2:0] {
      OP_READ = 3'h0,
      OP_READ_SPARE = 3'h1,
      OP_PROGRAM = 3'h2,
      OP_ERASE = 3'h3,
      OP_RESET = 3'h4,
      OP_STATUS = 3'h5,
      OP_READ_ID = 3'h6
   } op_t;

   typedef struct packed {
      op_t op;
      logic [22:0] addr;
   } req_t;

   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic read_strobe_n;
      logic spare_area_gate_old;
   } ctl_t;
endpackage : nand_host_pkg

// ---- hdl/byte_fifo.sv ----
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready_o = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // byte_fifo

// ---- hdl/nand_host.sv ----
/*
 Host controller that drives a byte-wide NAND flash through its pins: command,
 address and data cycles, ready/busy wait, write data through a 32-byte FIFO.
 Assumes the flash pins are joined by the bench; io and ready/busy are sampled async.
*/
`timescale 1ns/1ps
module nand_host (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Request
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire nand_host_pkg::req_t req_i,
   input wire logic spare_hide_i,
   // Write data
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   input wire logic [7:0] wr_data_i,
   // Read data
   output logic rd_valid_o,
   output logic [7:0] rd_data_o,
   output logic done_o,
   // Flash pins
   output nand_host_pkg::ctl_t ctl_o,
   output logic [7:0] io_o,
   output logic io_oe_n_o,
   input wire logic [7:0] io_i,
   input wire logic ready_busy_i
);
   typedef enum logic [3:0] {
      ST_POWERUP = 4'h0,
      ST_IDLE = 4'h1,
      ST_CMD = 4'h2,
      ST_ADDR = 4'h3,
      ST_DATA_OUT = 4'h4,
      ST_CMD2 = 4'h5,
      ST_WAIT = 4'h6,
      ST_READ = 4'h7,
      ST_DONE = 4'h8
   } state_t;

   state_t state;
   nand_host_pkg::req_t cur;
   logic [15:0] timer;
   logic [9:0] byte_cnt;
   logic [1:0] addr_idx;
   logic phase;
   logic [7:0] io_s1, io_s2;
   logic rb_s1, rb_s2;
   logic f_valid, f_ready;
   logic [7:0] f_data;
   logic tick;
   logic [1:0] addr_last;
   logic [1:0] addr_first;
   logic [7:0] addr_byte;
   logic [7:0] cmd1;

   always_ff @(posedge clk_i) begin
      io_s1 <= io_i;
      io_s2 <= io_s1;
      rb_s1 <= ready_busy_i;
      rb_s2 <= rb_s1;
   end

   byte_fifo #(.WIDTH(8), .DEPTH(32)) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(wr_valid_i),
      .in_ready_o(wr_ready_o),
      .in_data_i(wr_data_i),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready),
      .out_data_o(f_data)
   );

   assign tick = (timer == '0);
   assign req_ready_o = (state == ST_IDLE);

   // Lower or upper half picked by A8; the pointer is re-chosen on each read
   always_comb begin
      case (cur.op)
         nand_host_pkg::OP_READ: cmd1 = cur.addr[nand_host_pkg::A8_BIT] ?
            nand_host_pkg::CMD_READ_HI : nand_host_pkg::CMD_READ_LO;
         nand_host_pkg::OP_READ_SPARE: cmd1 = nand_host_pkg::CMD_READ_SPARE;
         nand_host_pkg::OP_PROGRAM: cmd1 = nand_host_pkg::CMD_PROG_SETUP;
         nand_host_pkg::OP_ERASE: cmd1 = nand_host_pkg::CMD_ERASE_SETUP;
         nand_host_pkg::OP_STATUS: cmd1 = nand_host_pkg::CMD_STATUS;
         nand_host_pkg::OP_READ_ID: cmd1 = nand_host_pkg::CMD_READ_ID;
         default: cmd1 = nand_host_pkg::CMD_RESET;
      endcase
   end

   // Erase sends only row bytes, read ID one byte, read, spare read and program all three
   always_comb begin
      addr_first = (cur.op == nand_host_pkg::OP_ERASE) ? 2'd1 : 2'd0;
      addr_last = (cur.op == nand_host_pkg::OP_READ_ID) ? 2'd0 : 2'd2;
      case (addr_idx)
         2'd0: addr_byte = cur.addr[nand_host_pkg::COL_LSB +: 8];
         2'd1: addr_byte = cur.addr[nand_host_pkg::ROW_LO_LSB +: 8];
         default: addr_byte = {2'b00, cur.addr[nand_host_pkg::ROW_HI_LSB +: nand_host_pkg::ROW_HI_W]};
      endcase
   end

   assign f_ready = (state == ST_DATA_OUT) && tick && phase && f_valid;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_POWERUP;
         timer <= 16'(nand_host_pkg::POWERUP_CYC);
         cur <= '0;
         byte_cnt <= '0;
         addr_idx <= '0;
         phase <= 1'b0;
         ctl_o <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1, spare_area_gate_old: 1'b0};
         io_o <= '0;
         io_oe_n_o <= 1'b1;
         rd_valid_o <= 1'b0;
         rd_data_o <= '0;
         done_o <= 1'b0;
      end else begin
         rd_valid_o <= 1'b0;
         done_o <= 1'b0;
         ctl_o.spare_area_gate_old <= spare_hide_i;
         if (!tick) begin
            timer <= timer - 1'b1;
         end
         case (state)
            ST_POWERUP: if (tick) state <= ST_IDLE;
            ST_IDLE: if (req_valid_i) begin
               cur <= req_i;
               state <= ST_CMD;
               phase <= 1'b0;
               ctl_o.ce_n <= 1'b0;
            end
            ST_CMD, ST_ADDR, ST_CMD2: if (tick) begin
               // Strobe low for setup, rise latches the byte
               timer <= 16'(nand_host_pkg::STROBE_CYC);
               phase <= ~phase;
               if (!phase) begin
                  ctl_o.we_n <= 1'b0;
                  io_oe_n_o <= 1'b0;
                  ctl_o.cle <= (state != ST_ADDR);
                  ctl_o.ale <= (state == ST_ADDR);
                  io_o <= (state == ST_ADDR) ? addr_byte : (state == ST_CMD2) ?
                     ((cur.op == nand_host_pkg::OP_ERASE) ? nand_host_pkg::CMD_ERASE_GO : nand_host_pkg::CMD_PROG_GO) :
                     cmd1;
                  if (state == ST_CMD) addr_idx <= addr_first;
               end else begin
                  ctl_o.we_n <= 1'b1;
                  if (state == ST_CMD2) begin
                     state <= ST_WAIT;
                     timer <= 16'(nand_host_pkg::BUSY_SETTLE_CYC);
                  end else if (state == ST_CMD) begin
                     if (cur.op == nand_host_pkg::OP_RESET) begin
                        state <= ST_WAIT;
                        timer <= 16'(nand_host_pkg::BUSY_SETTLE_CYC);
                     end else if (cur.op == nand_host_pkg::OP_STATUS) begin
                        state <= ST_READ;
                        byte_cnt <= 10'd1;
                     end else begin
                        state <= ST_ADDR;
                     end
                  end else if (addr_idx == addr_last) begin
                     byte_cnt <= 10'(nand_host_pkg::PAGE_BYTES);
                     if (cur.op == nand_host_pkg::OP_PROGRAM) state <= ST_DATA_OUT;
                     else if (cur.op == nand_host_pkg::OP_ERASE) state <= ST_CMD2;
                     else if (cur.op == nand_host_pkg::OP_READ_ID) begin
                        state <= ST_READ;
                        byte_cnt <= 10'd2;
                     end else begin
                        state <= ST_WAIT;
                        timer <= 16'(nand_host_pkg::BUSY_SETTLE_CYC);
                     end
                  end else begin
                     addr_idx <= addr_idx + 1'b1;
                  end
               end
            end
            ST_DATA_OUT: if (tick && (phase || f_valid)) begin
               // Whole page of write data, stalls while FIFO empty
               timer <= 16'(nand_host_pkg::STROBE_CYC);
               phase <= ~phase;
               ctl_o.cle <= 1'b0;
               ctl_o.ale <= 1'b0;
               if (!phase) begin
                  ctl_o.we_n <= 1'b0;
                  io_o <= f_data;
               end else begin
                  ctl_o.we_n <= 1'b1;
                  byte_cnt <= byte_cnt - 1'b1;
                  if (byte_cnt == 10'd1) state <= ST_CMD2;
               end
            end
            ST_WAIT: begin
               io_oe_n_o <= 1'b1;
               ctl_o.cle <= 1'b0;
               ctl_o.ale <= 1'b0;
               // Wait out busy; device works alone meanwhile
               if (tick && rb_s2) begin
                  if (cur.op == nand_host_pkg::OP_READ || cur.op == nand_host_pkg::OP_READ_SPARE) begin
                     state <= ST_READ;
                  end else begin
                     state <= ST_DONE;
                  end
               end
            end
            ST_READ: if (tick) begin
               io_oe_n_o <= 1'b1;
               ctl_o.cle <= 1'b0;
               ctl_o.ale <= 1'b0;
               timer <= 16'(nand_host_pkg::STROBE_CYC) + 16'd2;
               phase <= ~phase;
               if (!phase) begin
                  ctl_o.read_strobe_n <= 1'b0;
               end else begin
                  ctl_o.read_strobe_n <= 1'b1;
                  rd_valid_o <= 1'b1;
                  rd_data_o <= io_s2;
                  byte_cnt <= byte_cnt - 1'b1;
                  if (byte_cnt == 10'd1) state <= ST_DONE;
               end
            end
            ST_DONE: begin
               ctl_o.ce_n <= 1'b1;
               done_o <= 1'b1;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   chk_powerup_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(ctl_o.ce_n) |-> $past(state) != ST_POWERUP)
      else $error("chip select before power-up wait");
   chk_third_addr_top: assert property (@(posedge clk_i) disable iff (rst_i)
      (!ctl_o.we_n && ctl_o.ale && addr_idx == 2'd2) |-> io_o[7:6] == 2'b00)
      else $error("third address byte top bits not low");
   chk_strobe_select: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(ctl_o.we_n) |-> !ctl_o.ce_n && (ctl_o.cle || ctl_o.ale || state == ST_DATA_OUT || state == ST_CMD2))
      else $error("write strobe without select");
   chk_cle_ale_excl: assert property (@(posedge clk_i) disable iff (rst_i)
      !(ctl_o.cle && ctl_o.ale))
      else $error("command and address latch both high");
   chk_drive_read: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctl_o.read_strobe_n |-> io_oe_n_o)
      else $error("host drives io during read");
   chk_read_half: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ST_CMD && !phase && cur.op == nand_host_pkg::OP_READ && tick) |=>
      io_o == {7'h00, cur.addr[nand_host_pkg::A8_BIT]})
      else $error("read code does not match A8");
   chk_wait_ready: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ST_WAIT && !rb_s2) |=> state == ST_WAIT)
      else $error("left busy wait while busy");
   chk_reset_code: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ST_CMD && !phase && tick && cur.op == nand_host_pkg::OP_RESET) |=>
      io_o == nand_host_pkg::CMD_RESET && !ctl_o.we_n)
      else $error("reset code not sent");
endmodule // nand_host

// ---- tb/nand_flash_model.sv ----
/*
 Behavioural byte-wide NAND flash that answers the host controller.
 Assumes the bench resolves the shared io lines from the host enable alone.
*/
`timescale 1ns/1ps
module nand_flash_model #(
   parameter logic [7:0] ID_MAKER = 8'h3a, // Arbitrary value
   parameter logic [7:0] ID_DEVICE = 8'hc5, // Arbitrary value
   parameter int READ_BUSY_NS = 300
) (
   // Host pins
   input wire nand_host_pkg::ctl_t ctl_i,
   input wire logic [7:0] io_i,
   // Device pins
   output logic [7:0] io_o,
   output logic ready_busy_o
);
   logic [9:0] wire_log[$];
   logic [7:0] cmd = 8'h00;
   logic [22:0] addr = '0;
   logic upper = 1'b0;
   logic busy = 1'b0;
   int addr_n = 0;
   int col = 0;
   int id_n = 0;
   assign ready_busy_o = ~busy;
   initial io_o = 8'h00;
   task automatic hold_busy(input int ns);
      busy = 1'b1;
      #(ns);
      busy = 1'b0;
   endtask
   always @(posedge ctl_i.we_n) begin
      if (!ctl_i.ce_n) begin
         wire_log.push_back({ctl_i.cle, ctl_i.ale, io_i});
         if (ctl_i.cle) begin
            cmd = io_i;
            addr_n = (io_i == 8'h60) ? 1 : 0;
            id_n = 0;
            if (io_i <= 8'h01) upper = io_i[0];
            if (io_i == 8'hff) hold_busy(4800);
            if (io_i == 8'h10 || io_i == 8'hd0) hold_busy(2000);
         end else if (ctl_i.ale && addr_n < (cmd == 8'h90 ? 1 : 3)) begin
            if (addr_n == 0) addr[7:0] = io_i;
            if (addr_n == 1) addr[16:9] = io_i;
            if (addr_n == 2) addr[22:17] = io_i[5:0];
            addr_n++;
            if (addr_n == 3 && cmd != 8'h60) begin
               col = (cmd == 8'h50) ? 512 + addr[3:0] : {upper, addr[7:0]};
               upper = 1'b0;
               if (cmd != 8'h80) hold_busy(READ_BUSY_NS);
            end
         end
      end
   end
   always @(negedge ctl_i.read_strobe_n) begin
      if (!ctl_i.ce_n) begin
         if (cmd == 8'h70) io_o = {~busy, ~busy, 6'h00};
         else if (cmd == 8'h90) io_o = (id_n == 0) ? ID_MAKER : ID_DEVICE;
         else io_o = 8'(col >> 1);
         id_n++;
         col++;
      end
   end
   // Released lines show the inverse of the last byte
   always @(posedge ctl_i.read_strobe_n) begin
      #10;
      if (ctl_i.read_strobe_n) io_o = ~io_o;
   end
endmodule // nand_flash_model

// ---- tb/testbench.sv ----
/*
 Self-checking bench for the NAND host controller with a flash model.
 Assumes the design package and the flash model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0] ID_MAKER = 8'h3a; // Arbitrary value
   localparam logic [7:0] ID_DEVICE = 8'hc5; // Arbitrary value
   logic clk_i;
   logic rst_i;
   logic req_valid;
   nand_host_pkg::req_t req;
   logic spare_hide;
   logic wr_valid;
   logic [7:0] wr_data;
   logic req_ready, wr_ready, rd_valid, done, io_oe_n, ready_busy;
   logic [7:0] rd_data, host_io, dev_io;
   nand_host_pkg::ctl_t ctl;
   wire [7:0] io_bus;
   assign io_bus = io_oe_n ? dev_io : host_io;
   logic [7:0] exp_rd[$];
   logic [9:0] exp_log[$];
   logic [15:0] lfsr = 16'h003c;
   int err_total = 0;
   int samples_checked = 0;
   int wr_count = 0;
   always #2 clk_i = ~clk_i;
   nand_host i_dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid), .req_ready_o(req_ready),
      .req_i(req), .spare_hide_i(spare_hide), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready),
      .wr_data_i(wr_data), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .done_o(done), .ctl_o(ctl),
      .io_o(host_io), .io_oe_n_o(io_oe_n), .io_i(io_bus), .ready_busy_i(ready_busy));
   nand_flash_model #(.ID_MAKER(ID_MAKER), .ID_DEVICE(ID_DEVICE)) i_flash (
      .ctl_i(ctl), .io_i(io_bus), .io_o(dev_io), .ready_busy_o(ready_busy));
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] expect_v, input string msg);
      samples_checked++;
      if (seen !== expect_v) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s (saw %h, expected %h)", $time, msg, seen, expect_v);
      end
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic exp_addr(input logic [22:0] a, input bit with_col);
      if (with_col) exp_log.push_back({2'b01, a[7:0]});
      exp_log.push_back({2'b01, a[16:9]});
      exp_log.push_back({4'b0100, a[22:17]});
   endtask
   task automatic check_log();
      check(i_flash.wire_log.size(), exp_log.size(), "wire byte count");
      while (exp_log.size() > 0 && i_flash.wire_log.size() > 0)
         check(i_flash.wire_log.pop_front(), exp_log.pop_front(), "wire byte");
      exp_log.delete();
      i_flash.wire_log.delete();
      check(exp_rd.size(), 0, "read bytes missing");
   endtask
   task automatic run_op(input nand_host_pkg::op_t op, input logic [22:0] a);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req <= '{op: op, addr: a};
      do begin @(posedge clk_i); n++; end while (req_ready !== 1'b1 && n < 400);
      if (req_ready !== 1'b1) begin err_total++; report_and_stop(); end
      req_valid <= 1'b0;
      do begin @(posedge clk_i); n++; end while (done !== 1'b1 && n < 60000);
      if (n >= 60000) begin err_total++; report_and_stop(); end
   endtask
   task automatic push_bytes(input int upto, input int limit);
      int n;
      n = 0;
      wr_valid <= 1'b1;
      wr_data <= 8'(wr_count) ^ 8'ha5;
      do begin
         @(posedge clk_i);
         n++;
         if (wr_ready === 1'b1) begin
            wr_count++;
            wr_data <= 8'(wr_count) ^ 8'ha5;
         end
      end while (wr_count < upto && n < limit);
      wr_valid <= 1'b0;
   endtask
   always @(posedge clk_i) begin
      if (rd_valid === 1'b1) begin
         if (exp_rd.size() == 0) check(1, 0, "unexpected read byte");
         else check(rd_data, exp_rd.pop_front(), "read byte");
      end
   end
   initial begin
      logic [22:0] a;
      logic [15:0] r;
      int n;
      clk_i = 1'b0;
      rst_i <= 1'b1;
      req_valid <= 1'b0;
      req <= '0;
      spare_hide <= 1'b0;
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      n = 0;
      do begin @(posedge clk_i); n++; check(ctl.ce_n, 1, "select before ready"); end
      while (req_ready !== 1'b1 && n < 400);
      check(n >= nand_host_pkg::POWERUP_CYC, 1, "ready too early");
      $display("Power-up wait done");
      spare_hide <= 1'b1;
      repeat (3) @(posedge clk_i);
      check(ctl.spare_area_gate_old, 1, "spare gate high");
      spare_hide <= 1'b0;
      repeat (3) @(posedge clk_i);
      check(ctl.spare_area_gate_old, 0, "spare gate low");
      for (int h = 0; h < 2; h++) begin
         r = rnd();
         a = {r[6:0], rnd()};
         a[8] = h[0];
         exp_log.push_back({9'h100, h[0]});
         exp_addr(a, 1'b1);
         for (int i = 0; i < nand_host_pkg::PAGE_BYTES; i++) exp_rd.push_back(8'((32'(a[8:0]) + i) >> 1));
         run_op(nand_host_pkg::OP_READ, a);
         check_log();
         $display("Page read half %0d done", h);
      end
      exp_log.push_back(10'h250);
      exp_addr(a, 1'b1);
      for (int i = 0; i < nand_host_pkg::PAGE_BYTES; i++) exp_rd.push_back(8'((32'(a[3:0]) + 32'd512 + i) >> 1));
      run_op(nand_host_pkg::OP_READ_SPARE, a);
      check_log();
      exp_log.push_back(10'h290);
      exp_log.push_back(10'h100);
      exp_rd.push_back(ID_MAKER);
      exp_rd.push_back(ID_DEVICE);
      run_op(nand_host_pkg::OP_READ_ID, 23'h000000);
      check_log();
      exp_log.push_back(10'h270);
      exp_rd.push_back(8'hc0);
      run_op(nand_host_pkg::OP_STATUS, a);
      check_log();
      exp_log.push_back(10'h260);
      exp_addr(a, 1'b0);
      exp_log.push_back(10'h2d0);
      run_op(nand_host_pkg::OP_ERASE, a);
      check_log();
      exp_log.push_back(10'h2ff);
      run_op(nand_host_pkg::OP_RESET, a);
      check(ready_busy, 1, "done before ready");
      check_log();
      $display("Read spare, id, status, erase, reset done");
      push_bytes(nand_host_pkg::PAGE_BYTES, 40);
      check(wr_count, 32, "buffer depth");
      check(wr_ready, 0, "buffer full");
      exp_log.push_back(10'h280);
      exp_addr(a, 1'b1);
      for (int i = 0; i < nand_host_pkg::PAGE_BYTES; i++) exp_log.push_back({2'b00, 8'(i) ^ 8'ha5});
      exp_log.push_back(10'h210);
      @(posedge clk_i);
      fork
         run_op(nand_host_pkg::OP_PROGRAM, a);
         push_bytes(nand_host_pkg::PAGE_BYTES, 30000);
      join
      check_log();
      $display("Page program done");
      report_and_stop();
   end
endmodule // testbench
